/* include/clkgen_pkg.sv */
// Purpose: Shared constants of the clock generator register bank and its host.
// Assumes: Linear byte addresses are {page[3:0], offset[6:0]}.
// Notes: Reset and write-mask tables are functions called by the register bank's reset and write paths.
package clkgen_pkg;
  localparam int CLK_PERIOD_NS = 10;
  localparam int WRITE_GAP_MS = 25;
  localparam int WRITE_GAP_CYC = WRITE_GAP_MS * 1000000 / CLK_PERIOD_NS;
  localparam int PAGE_BYTES = 128;
  localparam int MEM_SLOTS = 5;
  localparam logic [2:0] SLOT_NONE = 3'h7;
  localparam logic [3:0] SLOT_PAGE [5] = '{4'h0, 4'h1, 4'h2, 4'hD, 4'hE};
  localparam logic [7:0] PG_SYNTH_MB = 8'h0D;
  localparam logic [7:0] PG_OUT_MB = 8'h0E;
  localparam logic [6:0] OFF_PAGE_PTR = 7'h7F;
  localparam logic [6:0] OFF_LOCK = 7'h7E;
  localparam logic [10:0] A_READY = 11'h000;
  localparam logic [10:0] A_PART = 11'h001;
  localparam logic [10:0] A_SIREV = 11'h003;
  localparam logic [10:0] A_FW = 11'h005;
  localparam logic [10:0] A_USERVER = 11'h007;
  localparam logic [10:0] A_VCO = 11'h00B;
  localparam logic [10:0] A_RSTFLAG = 11'h018;
  localparam logic [10:0] A_PINRST = 11'h019;
  localparam logic [10:0] A_OSC_RX = 11'h021;
  localparam logic [10:0] A_OSC_CFG = 11'h026;
  localparam logic [10:0] A_PLL_SRC = 11'h029;
  localparam logic [10:0] A_DIVINT = 11'h02A;
  localparam logic [10:0] A_DIVFRAC = 11'h02B;
  localparam logic [10:0] A_DIVSEC = 11'h030;
  localparam logic [10:0] A_CLKSTATE = 11'h032;
  localparam logic [10:0] A_SETUP = 11'h033;
  localparam logic [10:0] A_SERADDR = 11'h03E;
  localparam logic [10:0] A_CUST_LO = 11'h050;
  localparam logic [10:0] A_CUST_HI = 11'h06F;
  localparam logic [10:0] A_LOCK = 11'h07E;
  localparam logic [10:0] A_PININ = 11'h140;
  localparam int READY_BIT = 7;
  localparam int SETUP_BIT = 0;
  localparam int LOCKOUT_BIT = 7;
  localparam int FETCH_BIT = 0;
  localparam int COMMIT_BIT = 1;
  localparam logic [1:0] CLK_ST_IDLE = 2'h0;
  localparam logic [1:0] CLK_ST_RUN = 2'h2;
  localparam logic [1:0] CLK_ST_READY = 2'h3;
  localparam logic [7:0] DIVINT_MIN = 8'h10;
  localparam logic [7:0] DIVINT_MAX = 8'h43;
  localparam logic [7:0] DIVINT_DEF = 8'h34;
  localparam logic [7:0] DIVSEC_DEF = 8'h02;
  localparam logic [5:0] DIVSEC_FALLBACK = 6'h01;
  localparam logic [31:0] RST_USER_VER = 32'h0FFFFFFF;
  localparam logic [31:0] RST_VCO = 32'h02769140;
  localparam logic [31:0] RST_SMULT = 32'h12A05F20;
  localparam logic [7:0] RST_SERADDR = 8'h38;
  localparam logic [7:0] RST_ONE_LSB = 8'h01;
  localparam int NGRP = 18;
  localparam logic [10:0] GRP_START [18] = '{11'h001, 11'h005, 11'h007, 11'h00B,
    11'h019, 11'h02B, 11'h0E0, 11'h0E3, 11'h0E6, 11'h0E9, 11'h0EC, 11'h682,
    11'h686, 11'h688, 11'h68C, 11'h68E, 11'h690, 11'h702};
  localparam logic [2:0] GRP_LEN [18] = '{3'h2, 3'h2, 3'h4, 3'h4, 3'h2, 3'h5,
    3'h2, 3'h2, 3'h2, 3'h2, 3'h2, 3'h2, 3'h2, 3'h4, 3'h2, 3'h2, 3'h2, 3'h2};
  localparam int MB_MAXE = 10;
  localparam int MB_MAXW = 12;
  localparam logic [10:0] MB_HS [2] = '{11'h684, 11'h704};
  localparam logic [10:0] MB_MASK [2] = '{11'h682, 11'h702};
  localparam logic [10:0] MB_WIN [2] = '{11'h686, 11'h705};
  localparam int MB_WB [2] = '{12, 1};
  localparam int MB_NE [2] = '{5, 10};
  // Host command port map.
  localparam logic [3:0] U_ADDR_HI = 4'h0;
  localparam logic [3:0] U_ADDR_LO = 4'h1;
  localparam logic [3:0] U_LEN = 4'h2;
  localparam logic [3:0] U_DATA = 4'h3;
  localparam logic [3:0] U_GO = 4'h8;
  localparam logic [3:0] U_STATUS = 4'h9;
  localparam int GO_WR_BIT = 0;
  localparam int GO_RD_BIT = 1;
  localparam int ST_DONE_BIT = 1;
  localparam logic [2:0] MAX_LEN = 3'h5;

  function automatic logic [2:0] slot_of(input logic [7:0] pg);
    slot_of = SLOT_NONE;
    for (int s = 0; s < MEM_SLOTS; s++) begin
      if (pg == {4'h0, SLOT_PAGE[s]}) slot_of = 3'(s);
    end
  endfunction

  function automatic logic [7:0] byte_of(input logic [31:0] v, input logic [10:0] k);
    byte_of = v[8 * (3 - k[1:0]) +: 8];
  endfunction

  function automatic logic [7:0] reset_byte(input logic [10:0] a);
    reset_byte = 8'h00;
    if (a >= A_USERVER && a < A_VCO) reset_byte = byte_of(RST_USER_VER, a - A_USERVER);
    if (a >= A_VCO && a < A_VCO + 11'h4) reset_byte = byte_of(RST_VCO, a - A_VCO);
    if (a >= GRP_START[13] && a < GRP_START[14]) reset_byte = byte_of(RST_SMULT, a - GRP_START[13]);
    case (a)
      A_DIVINT: reset_byte = DIVINT_DEF;
      A_DIVSEC: reset_byte = DIVSEC_DEF;
      11'h683, 11'h687, 11'h68D, 11'h68F, 11'h703: reset_byte = RST_ONE_LSB;
      default: ;
    endcase
  endfunction

  // Writable bits per byte; zero bits are stored as zero.
  function automatic logic [7:0] wmask(input logic [10:0] a);
    wmask = 8'h00;
    if ((a >= A_USERVER && a < A_VCO + 11'h4) || (a >= A_CUST_LO && a <= A_CUST_HI) ||
        (a >= 11'h686 && a <= 11'h691)) wmask = 8'hFF;
    // Each pin owns three bytes; the third is its function byte.
    if (a >= 11'h0E0 && a <= 11'h0EE) wmask = ((a - 11'h0E0) % 11'h3 == 11'h2) ?
        8'h07 : 8'h7F;
    case (a)
      A_RSTFLAG, A_SETUP: wmask = 8'h01;
      A_OSC_RX, 11'h0EF, 11'h0F3, 11'h683: wmask = 8'h1F;
      11'h022, 11'h023, 11'h025, A_DIVINT, 11'h0F0, 11'h0F1, 11'h703, 11'h705: wmask = 8'hFF;
      11'h02B, 11'h02C, 11'h02D, 11'h02E, 11'h02F: wmask = 8'hFF;
      A_OSC_CFG: wmask = 8'h23;
      A_PLL_SRC: wmask = 8'h78;
      A_DIVSEC: wmask = 8'h3F;
      A_LOCK: wmask = 8'h80;
      11'h0F2: wmask = 8'h0F;
      11'h702: wmask = 8'h03;
      default: ;
    endcase
  endfunction
endpackage

/* include/clkgen_link_if.sv */
// Purpose: Byte register link between the host end and the register bank.
// Assumes: One clock; strobes are one cycle; read data follows one cycle later.
// Notes: Offset is the 7-bit in-page address.
`timescale 1ns/1ps
interface clkgen_link_if;
  logic [6:0] offset;
  logic [7:0] wdata;
  logic wr;
  logic rd;
  logic [7:0] rdata;
  modport dev (input offset, input wdata, input wr, input rd, output rdata);
  modport host (output offset, output wdata, output wr, output rd, input rdata);
endinterface

/* hw/clkgen_regbank.sv */
// Purpose: Paged byte register bank of the clock generator, device end.
// Assumes: Host keeps MSB-first order and write spacing.
// Notes: Mailbox pages stay closed until the system clock reports ready.
//
// Behaviour
// - All registers are byte-wide locations
// - Multi-byte registers are big-endian
// - Host accesses MSB first, LSB last
// - Multi-byte write takes effect on LSB
// - Host spaces same-location writes by 25 ms (host spaces consecutive writes to one location and any write after a PLL or VCO offset write)
// - Page pointer accepts back-to-back writes
// - Host waits after PLL setup changes
// - Host leaves VCO offset alone in operation (host drops VCO writes only after its own setup write, not in automatic mode)
// - Mailbox pages ignored until ready
// - Status bit 7 shows PLL ready
// - Pages sit at documented linear bases
// - VCO offset is signed fraction of nominal
// - VCO derives from input times dividers
// - Firmware number bit 15 marks unreleased
// - User setup version stores host value
// - Automatic and managed operating modes
// - Everything reached through register access
// - Customer scratch bytes reset to zero
// - Page pointer at offset 0x7F every page
// - Mailbox fetch and commit handshake
// - Setup latched on first rising setup bit
`timescale 1ns/1ps
module clkgen_regbank #(
  parameter int PLL_LOCK_CYCLES = 1000,
  parameter logic [15:0] PART_ID = 16'hA5C3, // arbitrary value
  parameter logic [7:0] SI_REV = 8'h5A, // arbitrary value
  parameter logic [15:0] FW_REV = 16'h0101, // arbitrary value
  parameter logic UNRELEASED = 1'b0
) (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic rst_i,
  // Host link
  clkgen_link_if.dev link,
  // Pins and straps
  input wire logic [4:0] pins_i,
  input wire logic auto_mode_i,
  // Ready, clock state and latched system clock setup
  output logic ready_o,
  output logic [1:0] clk_state_o,
  output logic [31:0] vco_offset_o,
  output logic [7:0] div_int_o,
  output logic [35:0] div_frac_o,
  output logic [5:0] div_sec_o
);

  //////////////////////////////////////////////////////////////////////////////

  typedef struct packed {
    logic [7:0] page;
    logic [639:0][7:0] mem;
    logic [3:0][7:0] pend;
    logic [1:0][9:0][11:0][7:0] box;
    logic [7:0] rdata;
    logic setup_prev;
    logic latched;
    logic ready;
    logic [15:0] lock_cnt;
    logic strap_done;
    logic [4:0] straps;
    logic auto_mode;
    logic [31:0] vco;
    logic [7:0] div_int;
    logic [35:0] div_frac;
    logic [5:0] div_sec;
    logic [1:0] cst;
  } bank_s;

  bank_s q;
  bank_s d;
  logic [10:0] lin;
  logic [10:0] gs;
  logic [2:0] gl;
  logic [2:0] pos;
  logic [15:0] tmask;
  logic [3:0] sel;
  logic is_open;
  logic locked;
  logic hs_hit;
  logic sb;
  logic [7:0] di;
  logic [5:0] ds;

  // Memory byte index {slot, offset} of a linear address; callers only use mapped pages.
  function automatic logic [9:0] mix(input logic [10:0] a);
    mix = {clkgen_pkg::slot_of({4'h0, a[10:7]}), a[6:0]};
  endfunction

  //////////////////////////////////////////////////////////////////////////////

  always_comb begin
    d = q;
    lin = {q.page[3:0], link.offset};
    if (link.offset == clkgen_pkg::OFF_LOCK) lin = clkgen_pkg::A_LOCK;
    // Pages outside the map, or above 15, are simply not decoded.
    is_open = clkgen_pkg::slot_of(q.page) != clkgen_pkg::SLOT_NONE;
    if ((q.page == clkgen_pkg::PG_SYNTH_MB || q.page == clkgen_pkg::PG_OUT_MB) && !q.ready) begin
      is_open = 1'b0;
    end
    locked = q.mem[mix(clkgen_pkg::A_LOCK)][clkgen_pkg::LOCKOUT_BIT];
    gs = lin;
    gl = 3'h1;
    pos = 3'h0;
    tmask = 16'h0000;
    sel = 4'h0;
    hs_hit = 1'b0;
    sb = q.mem[mix(clkgen_pkg::A_SETUP)][clkgen_pkg::SETUP_BIT];
    di = q.mem[mix(clkgen_pkg::A_DIVINT)];
    ds = q.mem[mix(clkgen_pkg::A_DIVSEC)][5:0];

    // Read path: data stand in the cycle after the strobe.
    if (link.rd) begin
      if (link.offset == clkgen_pkg::OFF_PAGE_PTR) begin
        d.rdata = q.page;
      end else if (!is_open) begin
        d.rdata = 8'h00;
      end else begin
        case (lin)
          clkgen_pkg::A_READY: d.rdata = {q.ready, 7'h00};
          clkgen_pkg::A_PART: d.rdata = PART_ID[15:8];
          clkgen_pkg::A_PART + 11'h1: d.rdata = PART_ID[7:0];
          clkgen_pkg::A_SIREV: d.rdata = SI_REV;
          clkgen_pkg::A_FW: d.rdata = {UNRELEASED, FW_REV[14:8]};
          clkgen_pkg::A_FW + 11'h1: d.rdata = FW_REV[7:0];
          clkgen_pkg::A_PINRST + 11'h1: d.rdata = {3'h0, q.straps};
          clkgen_pkg::A_CLKSTATE: d.rdata = {6'h00, q.cst};
          clkgen_pkg::A_SERADDR: d.rdata = clkgen_pkg::RST_SERADDR;
          clkgen_pkg::A_PININ: d.rdata = {3'h0, pins_i};
          // Handshake bits self-clear, so they always read as zero.
          clkgen_pkg::MB_HS[0], clkgen_pkg::MB_HS[1]: d.rdata = 8'h00;
          default: d.rdata = q.mem[mix(lin)];
        endcase
      end
    end

    // Write path.
    if (link.wr) begin
      if (link.offset == clkgen_pkg::OFF_PAGE_PTR) begin
        d.page = link.wdata;
      end else if (is_open && (!locked || lin == clkgen_pkg::A_LOCK)) begin
        for (int m = 0; m < 2; m++) begin
          if (lin == clkgen_pkg::MB_HS[m]) begin
            hs_hit = 1'b1;
            tmask = {q.mem[mix(clkgen_pkg::MB_MASK[m])],
                     q.mem[mix(clkgen_pkg::MB_MASK[m] + 11'h1)]};
            for (int e = clkgen_pkg::MB_MAXE - 1; e >= 0; e--) begin
              if (e < clkgen_pkg::MB_NE[m] && tmask[e]) sel = 4'(e);
            end
            // Commit copies the window into every selected entry.
            if (link.wdata[clkgen_pkg::COMMIT_BIT]) begin
              for (int e = 0; e < clkgen_pkg::MB_MAXE; e++) begin
                for (int w = 0; w < clkgen_pkg::MB_MAXW; w++) begin
                  if (e < clkgen_pkg::MB_NE[m] && w < clkgen_pkg::MB_WB[m] && tmask[e]) begin
                    d.box[m][e][w] = q.mem[mix(clkgen_pkg::MB_WIN[m] + 11'(w))];
                  end
                end
              end
            end
            // Fetch loads the lowest selected entry into the window.
            if (link.wdata[clkgen_pkg::FETCH_BIT]) begin
              for (int w = 0; w < clkgen_pkg::MB_MAXW; w++) begin
                if (w < clkgen_pkg::MB_WB[m]) begin
                  d.mem[mix(clkgen_pkg::MB_WIN[m] + 11'(w))] = q.box[m][sel][w];
                end
              end
            end
          end
        end
        if (!hs_hit) begin
          for (int k = 0; k < clkgen_pkg::NGRP; k++) begin
            if (lin >= clkgen_pkg::GRP_START[k] &&
                lin < clkgen_pkg::GRP_START[k] + 11'(clkgen_pkg::GRP_LEN[k])) begin
              gs = clkgen_pkg::GRP_START[k];
              gl = clkgen_pkg::GRP_LEN[k];
            end
          end
          pos = 3'(lin - gs);
          // Earlier bytes wait in a holding buffer; the last byte commits all.
          if (pos == gl - 3'h1) begin
            for (int j = 0; j < 4; j++) begin
              if (3'(j) < pos) begin
                d.mem[mix(gs + 11'(j))] = q.pend[j] & clkgen_pkg::wmask(gs + 11'(j));
              end
            end
            d.mem[mix(lin)] = link.wdata & clkgen_pkg::wmask(lin);
          end else begin
            d.pend[pos[1:0]] = link.wdata;
          end
        end
      end
    end

    // Straps are caught in the first cycle after reset release.
    if (!q.strap_done) begin
      d.strap_done = 1'b1;
      d.straps = pins_i;
      d.auto_mode = auto_mode_i;
    end

    // Automatic mode starts from the reset values without host help.
    d.setup_prev = sb;
    if (!q.latched && ((sb && !q.setup_prev) || (q.auto_mode && q.strap_done))) begin
      d.latched = 1'b1;
      d.vco = {q.mem[mix(clkgen_pkg::A_VCO)], q.mem[mix(clkgen_pkg::A_VCO + 11'h1)],
               q.mem[mix(clkgen_pkg::A_VCO + 11'h2)],
               q.mem[mix(clkgen_pkg::A_VCO + 11'h3)]};
      d.div_int = (di < clkgen_pkg::DIVINT_MIN || di > clkgen_pkg::DIVINT_MAX) ?
                  clkgen_pkg::DIVINT_DEF : di;
      // The top four fraction bits are stored but unused.
      d.div_frac = {q.mem[mix(clkgen_pkg::A_DIVFRAC)][3:0],
                    q.mem[mix(clkgen_pkg::A_DIVFRAC + 11'h1)],
                    q.mem[mix(clkgen_pkg::A_DIVFRAC + 11'h2)],
                    q.mem[mix(clkgen_pkg::A_DIVFRAC + 11'h3)],
                    q.mem[mix(clkgen_pkg::A_DIVFRAC + 11'h4)]};
      d.div_sec = (ds == 6'h00) ? clkgen_pkg::DIVSEC_FALLBACK : ds;
    end
    // Lock is modelled as a fixed wait after the setup is taken.
    if (q.latched && !q.ready) begin
      d.lock_cnt = q.lock_cnt + 16'h0001;
      if (q.lock_cnt == 16'(PLL_LOCK_CYCLES - 1)) d.ready = 1'b1;
    end
    d.cst = d.ready ? clkgen_pkg::CLK_ST_READY :
            (d.latched ? clkgen_pkg::CLK_ST_RUN : clkgen_pkg::CLK_ST_IDLE);

    if (rst_i) begin
      d = '0;
      for (int s = 0; s < clkgen_pkg::MEM_SLOTS; s++) begin
        for (int o = 0; o < clkgen_pkg::PAGE_BYTES; o++) begin
          d.mem[s * clkgen_pkg::PAGE_BYTES + o] =
            clkgen_pkg::reset_byte({clkgen_pkg::SLOT_PAGE[s], 7'(o)});
        end
      end
      for (int m = 0; m < 2; m++) begin
        for (int e = 0; e < clkgen_pkg::MB_MAXE; e++) begin
          for (int w = 0; w < clkgen_pkg::MB_MAXW; w++) begin
            d.box[m][e][w] = clkgen_pkg::reset_byte(clkgen_pkg::MB_WIN[m] + 11'(w));
          end
        end
      end
    end
  end

  always_ff @(posedge core_clk_i) begin
    q <= d;
  end

  //////////////////////////////////////////////////////////////////////////////

  assign link.rdata = q.rdata;
  assign ready_o = q.ready;
  assign clk_state_o = q.cst;
  assign vco_offset_o = q.vco;
  assign div_int_o = q.div_int;
  assign div_frac_o = q.div_frac;
  assign div_sec_o = q.div_sec;

endmodule

/* hw/clkgen_host.sv */
// Purpose: Host end; turns linear multi-byte commands into paged byte accesses.
// Assumes: Software programs the command port and polls its status.
// Notes: Only the last written location is tracked for write spacing.
`timescale 1ns/1ps
module clkgen_host #(
  parameter int GAP_CYCLES = clkgen_pkg::WRITE_GAP_CYC
) (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic rst_i,
  // Command port
  input wire logic [3:0] cmd_addr_i,
  input wire logic [7:0] cmd_wdata_i,
  input wire logic cmd_wr_i,
  input wire logic cmd_rd_i,
  output logic [7:0] cmd_rdata_o,
  // Register link
  clkgen_link_if.host link
);

  //////////////////////////////////////////////////////////////////////////////

  typedef enum logic [5:0] {
    H_IDLE = 6'b000001,
    H_PAGE = 6'b000010,
    H_ACC = 6'b000100,
    H_RDWAIT = 6'b001000,
    H_RDCAP = 6'b010000,
    H_NEXT = 6'b100000
  } host_e;

  typedef struct packed {
    host_e st;
    logic [10:0] addr;
    logic [2:0] len;
    logic [4:0][7:0] data;
    logic [2:0] idx;
    logic op_rd;
    logic busy;
    logic done;
    logic [7:0] page;
    logic [10:0] last_wr;
    logic settle;
    logic setup_set;
    logic [21:0] gap;
    logic [6:0] offset;
    logic [7:0] wdata;
    logic wr;
    logic rd;
    logic [7:0] urdata;
  } host_s;

  host_s q;
  host_s d;
  logic [10:0] cur;
  logic analog;

  //////////////////////////////////////////////////////////////////////////////

  always_comb begin
    d = q;
    d.wr = 1'b0;
    d.rd = 1'b0;
    cur = q.addr + 11'(q.idx);
    analog = (cur >= clkgen_pkg::A_OSC_RX && cur <= clkgen_pkg::A_DIVSEC) ||
             (cur >= clkgen_pkg::A_VCO && cur < clkgen_pkg::A_VCO + 11'h4);
    if (q.gap != 22'h0) d.gap = q.gap - 22'h1;

    // Command port.
    if (cmd_rd_i) begin
      case (cmd_addr_i)
        clkgen_pkg::U_ADDR_HI: d.urdata = {5'h00, q.addr[10:8]};
        clkgen_pkg::U_ADDR_LO: d.urdata = q.addr[7:0];
        clkgen_pkg::U_LEN: d.urdata = {5'h00, q.len};
        clkgen_pkg::U_STATUS: d.urdata = {6'h00, q.done, q.busy};
        default: d.urdata = (cmd_addr_i >= clkgen_pkg::U_DATA && cmd_addr_i < clkgen_pkg::U_GO) ?
                            q.data[3'(cmd_addr_i - clkgen_pkg::U_DATA)] : 8'h00;
      endcase
    end
    if (cmd_wr_i && !q.busy) begin
      case (cmd_addr_i)
        clkgen_pkg::U_ADDR_HI: d.addr[10:8] = cmd_wdata_i[2:0];
        clkgen_pkg::U_ADDR_LO: d.addr[7:0] = cmd_wdata_i;
        clkgen_pkg::U_LEN: d.len = cmd_wdata_i[2:0];
        clkgen_pkg::U_GO: begin
          if (q.len != 3'h0 && q.len <= clkgen_pkg::MAX_LEN &&
              (cmd_wdata_i[clkgen_pkg::GO_WR_BIT] ^ cmd_wdata_i[clkgen_pkg::GO_RD_BIT])) begin
            d.busy = 1'b1;
            d.op_rd = cmd_wdata_i[clkgen_pkg::GO_RD_BIT];
            d.idx = 3'h0;
            d.st = H_PAGE;
          end
        end
        default: begin
          if (cmd_addr_i >= clkgen_pkg::U_DATA && cmd_addr_i < clkgen_pkg::U_GO) begin
            d.data[3'(cmd_addr_i - clkgen_pkg::U_DATA)] = cmd_wdata_i;
          end
        end
      endcase
    end
    if (cmd_wr_i && cmd_addr_i == clkgen_pkg::U_STATUS && cmd_wdata_i[clkgen_pkg::ST_DONE_BIT]) begin
      d.done = 1'b0;
    end

    // Link sequencer; bytes go out in rising address order, MSB first.
    case (q.st)
      H_IDLE: ;
      H_PAGE: begin
        if (cur[10:7] != q.page[3:0]) begin
          d.wr = 1'b1;
          d.offset = clkgen_pkg::OFF_PAGE_PTR;
          d.wdata = {4'h0, cur[10:7]};
          d.page = {4'h0, cur[10:7]};
        end
        d.st = H_ACC;
      end
      H_ACC: begin
        if (cur[10:7] != q.page[3:0]) begin
          d.st = H_PAGE;
        end else if (q.op_rd) begin
          d.rd = 1'b1;
          d.offset = cur[6:0];
          d.st = H_RDWAIT;
        end else if (q.gap == 22'h0 || (cur != q.last_wr && !q.settle)) begin
          // A VCO offset write after setup is dropped to avoid a long resettle.
          if (!(q.setup_set && cur >= clkgen_pkg::A_VCO && cur < clkgen_pkg::A_VCO + 11'h4)) begin
            d.wr = 1'b1;
          end
          d.offset = cur[6:0];
          d.wdata = q.data[q.idx];
          d.last_wr = cur;
          d.settle = analog;
          d.gap = 22'(GAP_CYCLES - 1);
          if (cur == clkgen_pkg::A_SETUP && q.data[q.idx][clkgen_pkg::SETUP_BIT]) begin
            d.setup_set = 1'b1;
          end
          d.st = H_NEXT;
        end
      end
      H_RDWAIT: d.st = H_RDCAP;
      H_RDCAP: begin
        d.data[q.idx] = link.rdata;
        d.st = H_NEXT;
      end
      H_NEXT: begin
        if (q.idx == q.len - 3'h1) begin
          d.busy = 1'b0;
          d.done = 1'b1;
          d.st = H_IDLE;
        end else begin
          d.idx = q.idx + 3'h1;
          d.st = H_ACC;
        end
      end
      default: d.st = H_IDLE;
    endcase

    if (rst_i) begin
      d = '0;
      d.st = H_IDLE;
    end
  end

  always_ff @(posedge core_clk_i) begin
    q <= d;
  end

  //////////////////////////////////////////////////////////////////////////////

  assign link.offset = q.offset;
  assign link.wdata = q.wdata;
  assign link.wr = q.wr;
  assign link.rd = q.rd;
  assign cmd_rdata_o = q.urdata;

endmodule

/* sim/clkgen_link_checker.sv */
// Purpose: Watches the byte link between host end and register bank.
// Assumes: One clock; page pointer is offset 7'h7F on every page.
// Notes: Tracks the page pointer itself to judge paged reads.
`timescale 1ns/1ps
module clkgen_link_checker (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic rst_i,
  // Link
  input wire logic [6:0] offset,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [7:0] rdata,
  // Device state
  input wire logic ready_o,
  input wire logic [1:0] clk_state_o,
  input wire logic [31:0] vco_offset_o
);
  logic [7:0] page_q;
  always_ff @(posedge core_clk_i) begin
    if (rst_i) page_q <= 8'h00;
    else if (wr && offset == 7'h7F) page_q <= wdata;
  end
  ////////////////////////////////////////////////////////////////////
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (rst_i);
  property p_one_strobe; !(wr && rd); endproperty
  a_one_strobe: assert property (p_one_strobe) else $error("both strobes");
  property p_rd_pulse; rd |=> !rd; endproperty
  a_rd_pulse: assert property (p_rd_pulse) else $error("long read strobe");
  property p_rdata_hold; !rd |=> $stable(rdata); endproperty
  a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved");
  property p_ready_state; ready_o |-> clk_state_o == 2'h3; endproperty
  a_ready_state: assert property (p_ready_state) else $error("ready state");
  property p_ready_rise; $rose(ready_o) |-> $past(clk_state_o) == 2'h2; endproperty
  a_ready_rise: assert property (p_ready_rise) else $error("ready too early");
  property p_mb_closed;
    rd && offset != 7'h7F && page_q inside {8'h0D, 8'h0E} && !ready_o |=> rdata == 8'h00;
  endproperty
  a_mb_closed: assert property (p_mb_closed) else $error("mailbox open");
  property p_status;
    rd && page_q == 8'h00 && offset == 7'h00 |=> rdata == {$past(ready_o), 7'h00};
  endproperty
  a_status: assert property (p_status) else $error("status byte");
  property p_latch; clk_state_o != 2'h0 |=> $stable(vco_offset_o); endproperty
  a_latch: assert property (p_latch) else $error("setup relatched");
  property p_page_seq; wr && offset == 7'h7F |=> (wr || rd) && offset != 7'h7F; endproperty
  a_page_seq: assert property (p_page_seq) else $error("no access after page");
endmodule

/* sim/clock_gen_host_register_map_tb.sv */
// Purpose: Drives the host command port; both ends joined by the link.
// Assumes: Short write gap and lock time to keep the run brief.
// Notes: Write offsets on the link are logged to check byte order.
`timescale 1ns/1ps
module clock_gen_host_register_map_tb;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [3:0] ca = 4'h0;
  logic [7:0] cd = 8'h00;
  logic cw = 1'b0;
  logic cr = 1'b0;
  logic [7:0] crd;
  logic ready;
  logic [1:0] cst;
  logic [31:0] vco;
  logic am = 1'b0;
  logic [7:0] dint;
  logic [35:0] dfrac;
  logic [5:0] dsec;
  logic [31:0] wlog = 32'h0;
  int n_mismatch = 0;
  int num_checks = 0;
  clkgen_link_if lnk();
  clkgen_host #(.GAP_CYCLES(8)) u_clkgen_host (.core_clk_i(clk), .rst_i(rst),
    .cmd_addr_i(ca), .cmd_wdata_i(cd), .cmd_wr_i(cw), .cmd_rd_i(cr),
    .cmd_rdata_o(crd), .link(lnk.host));
  clkgen_regbank #(.PLL_LOCK_CYCLES(4)) u_clkgen_regbank (.core_clk_i(clk),
    .rst_i(rst), .link(lnk.dev), .pins_i(5'h15), .auto_mode_i(am),
    .ready_o(ready), .clk_state_o(cst), .vco_offset_o(vco), .div_int_o(dint),
    .div_frac_o(dfrac), .div_sec_o(dsec));
  clkgen_link_checker u_clkgen_link_checker (.core_clk_i(clk), .rst_i(rst),
    .offset(lnk.offset), .wdata(lnk.wdata), .wr(lnk.wr), .rd(lnk.rd),
    .rdata(lnk.rdata), .ready_o(ready), .clk_state_o(cst), .vco_offset_o(vco));
  always #5 clk = ~clk;
  always @(posedge clk) if (lnk.wr === 1'b1) wlog <= {wlog[23:0], 1'b0, lnk.offset};
  ////////////////////////////////////////////////////////////////////
  task automatic wreg(input logic [3:0] a, input logic [7:0] d);
    ca <= a;
    cd <= d;
    cw <= 1'b1;
    @(posedge clk);
    cw <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rreg(input logic [3:0] a, output logic [7:0] d);
    ca <= a;
    cr <= 1'b1;
    @(posedge clk);
    cr <= 1'b0;
    @(posedge clk);
    d = crd;
  endtask
  task automatic chk(input logic [39:0] got, input logic [39:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // One command: linear address, byte count, direction; read data returned in d.
  task automatic op(input logic [10:0] a, input int n, input logic w, inout logic [39:0] d);
    logic [7:0] b;
    int k;
    wreg(4'h0, {5'h00, a[10:8]});
    wreg(4'h1, a[7:0]);
    wreg(4'h2, 8'(n));
    for (int i = 0; i < n; i++) wreg(4'(3 + i), d[8 * (n - 1 - i) +: 8]);
    wreg(4'h8, w ? 8'h01 : 8'h02);
    b = 8'h00;
    for (k = 0; k < 100 && b[1] !== 1'b1; k++) rreg(4'h9, b);
    chk({39'h0, b[1]}, 40'h1);
    wreg(4'h9, 8'h02);
    for (int i = 0; i < n && !w; i++) begin
      rreg(4'(3 + i), b);
      d[8 * (n - 1 - i) +: 8] = b;
    end
  endtask
  task automatic wr(input logic [10:0] a, input int n, input logic [39:0] v);
    logic [39:0] d;
    d = v;
    op(a, n, 1'b1, d);
  endtask
  task automatic rd(input logic [10:0] a, input int n, input logic [39:0] exp);
    logic [39:0] d;
    d = 40'h0;
    op(a, n, 1'b0, d);
    chk(d, exp);
  endtask
  ////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    rd(11'h000, 1, 40'h00);
    rd(11'h007, 4, 40'h0FFFFFFF);
    rd(11'h00B, 4, 40'h02769140);
    rd(11'h050, 1, 40'h00);
    rd(11'h019, 2, 40'h0015);
    rd(11'h140, 1, 40'h15);
  endtask
  task automatic t_early_mb;
    wr(11'h682, 2, 40'h0003);
    rd(11'h682, 2, 40'h0000);
  endtask
  task automatic t_vco;
    wr(11'h00B, 4, 40'h046AAAAB);
    chk({8'h00, wlog}, 40'h0B0C0D0E);
    rd(11'h00B, 4, 40'h046AAAAB);
    wr(11'h007, 4, 40'h12345678);
    rd(11'h007, 4, 40'h12345678);
    wr(11'h007, 1, 40'hAB);
    rd(11'h007, 4, 40'h12345678);
  endtask
  task automatic t_setup;
    wr(11'h02B, 5, 40'hF123456789);
    wr(11'h02A, 1, 40'h05);
    wr(11'h030, 1, 40'h00);
    wr(11'h033, 1, 40'hFF);
    rd(11'h033, 1, 40'h01);
    repeat (50) if (ready !== 1'b1) @(posedge clk);
    chk({38'h0, cst}, 40'h3);
    chk({8'h00, vco}, 40'h046AAAAB);
    chk({4'h0, dfrac}, 40'h123456789);
    chk({32'h0, dint}, 40'h34);
    chk({34'h0, dsec}, 40'h01);
    rd(11'h000, 1, 40'h80);
  endtask
  task automatic t_mailbox;
    wr(11'h686, 2, 40'h1234);
    wr(11'h684, 1, 40'h02);
    wr(11'h686, 2, 40'h0000);
    wr(11'h684, 1, 40'h01);
    rd(11'h686, 2, 40'h1234);
    rd(11'h684, 1, 40'h00);
  endtask
  task automatic t_auto;
    am <= 1'b1;
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    repeat (12) @(posedge clk);
    chk({38'h0, cst}, 40'h3);
    chk({8'h00, vco}, 40'h02769140);
  endtask
  task automatic final_report;
    $display("checks=%0d mismatches=%0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_reset();
    t_early_mb();
    t_vco();
    t_setup();
    t_mailbox();
    t_auto();
    final_report();
  end
  initial begin
    repeat (40000) @(posedge clk);
    n_mismatch++;
    final_report();
  end
endmodule
